//--- spsq_pkg.sv
package spsq_pkg;
    // Cycle figures at 50 MHz; plain defaults where nothing is documented
    localparam int SPSQ_CLK_HZ = 50_000_000;
    localparam int SPSQ_SCAN_TMO_MS = 2000;
    localparam int SPSQ_SCAN_TMO_CYC = SPSQ_SCAN_TMO_MS * (SPSQ_CLK_HZ / 1000);
    localparam int SPSQ_LASER_CHK_US = 500;
    localparam int SPSQ_LASER_CHK_CYC = SPSQ_LASER_CHK_US * (SPSQ_CLK_HZ / 1_000_000);
    localparam int SPSQ_BD_NOM_CYC = 20000;
    localparam int SPSQ_BD_TOL_CYC = 200;
    localparam int SPSQ_SHEET_TMO_MS = 1000;
    localparam int SPSQ_SHEET_TMO_CYC = SPSQ_SHEET_TMO_MS * (SPSQ_CLK_HZ / 1000);
    localparam int SPSQ_LOCK_LINES = 16;
    localparam int SPSQ_MOTOR_SPINUP_CYC = 1000;
    localparam int SPSQ_LAST_ROT_MS = 100;
    localparam int SPSQ_LAST_ROT_CYC = SPSQ_LAST_ROT_MS * (SPSQ_CLK_HZ / 1000);
    localparam logic [2:0] SPSQ_LCTL_OFF = 3'h0;
    localparam logic [2:0] SPSQ_LCTL_FORCE = 3'h7;
    localparam logic [2:0] SPSQ_LCTL_VIDEO = 3'h1;
    localparam logic [2:0] SPSQ_LCTL_ERASE = 3'h3;
    localparam int SPSQ_CNT_W = 32;
endpackage : spsq_pkg

//--- spsq_timer.sv
`timescale 1ns/1ps
// Restartable up-counter with expiry flag
module spsq_timer #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Control
    input wire logic clear_i,
    input wire logic run_i,
    input wire logic [W-1:0] limit_i,
    // Status
    output logic [W-1:0] count_o,
    output logic expired_o
);
    always_ff @(posedge clock_i) begin
        if (!nrst_i || clear_i) begin
            count_o <= '0;
        end else if (run_i && count_o != limit_i) begin
            count_o <= count_o + W'(1);
        end
    end

    assign expired_o = run_i && (count_o == limit_i);
endmodule : spsq_timer

//--- spsq_bd_meter.sv
`timescale 1ns/1ps
// Beam-detect edge finder and interval measurement
module spsq_bd_meter #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Beam detect, active low
    input wire logic beam_detect_in_n_i,
    // Window
    input wire logic [W-1:0] nom_i,
    input wire logic [W-1:0] tol_i,
    // Results
    output logic bd_pulse_o,
    output logic [W-1:0] interval_o,
    output logic in_window_o,
    output logic seen_o
);
    logic bd_d_r;
    logic [W-1:0] run_r;

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            bd_d_r <= 1'b1;
        end else begin
            bd_d_r <= beam_detect_in_n_i;
        end
    end

    assign bd_pulse_o = bd_d_r && !beam_detect_in_n_i;

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            run_r <= '0;
            interval_o <= '0;
            seen_o <= 1'b0;
        end else if (bd_pulse_o) begin
            run_r <= '0;
            interval_o <= run_r;
            seen_o <= 1'b1;
        end else if (run_r != '1) begin
            run_r <= run_r + W'(1);
        end
    end

    // Live interval check, also catches a missing pulse
    assign in_window_o = (run_r <= nom_i + tol_i) &&
        (!bd_pulse_o || run_r + tol_i >= nom_i);
endmodule : spsq_bd_meter

//--- spsq_sequencer.sv
`timescale 1ns/1ps
// Function
// - A print command asserts the scanner speed drive so the mirror motor spins.
// - Once the scanner turns, the laser-control lines force emission to obtain beam detect.
// - Scanner speed is derived from beam-detect timing and the drive is adjusted to hold it.
// - Video is forwarded as two differential pairs only while the scanner is at constant speed.
// - The laser path carries two independent video channels, one per diode.
// - Missing laser intensity after the forced-on check time is a laser failure; the code checks only if the scanner has not locked by then.
// - A beam-detect interval outside the window during printing is a beam-detect failure.
// - A scanner not locked within the start-up timeout is a scanner start-up failure.
// - The laser fires for drum charge elimination only in the final post-print rotation.
// - A print command turns on the feed, drum and scanner motors.
// - After the motors run, the feed clutch engages and then the pickup solenoid fires.
// - Media at the pre-feed sensor releases the clutch to stage the sheet.
// - The clutch re-engages on the staged sheet only once the scanner is ready.
// - Media not arriving at or clearing a path sensor in time halts the engine with a jam.
// - A jam stops the print in progress and notifies the formatter.
module spsq_sequencer
    import spsq_pkg::*;
#(
    parameter int SCAN_TMO_CYC = spsq_pkg::SPSQ_SCAN_TMO_CYC,
    parameter int LASER_CHK_CYC = spsq_pkg::SPSQ_LASER_CHK_CYC,
    parameter int BD_NOM_CYC = spsq_pkg::SPSQ_BD_NOM_CYC,
    parameter int BD_TOL_CYC = spsq_pkg::SPSQ_BD_TOL_CYC,
    parameter int SHEET_TMO_CYC = spsq_pkg::SPSQ_SHEET_TMO_CYC,
    parameter int LOCK_LINES = spsq_pkg::SPSQ_LOCK_LINES,
    parameter int SPINUP_CYC = spsq_pkg::SPSQ_MOTOR_SPINUP_CYC,
    parameter int LAST_ROT_CYC = spsq_pkg::SPSQ_LAST_ROT_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Formatter
    input wire logic print_cmd_i,
    input wire logic video_ch1_i,
    input wire logic video_ch2_i,
    output logic laser_fail_o,
    output logic bd_fail_o,
    output logic scanner_fail_o,
    output logic jam_o,
    output logic busy_o,
    // Laser/scanner unit
    output logic scanner_speed_drive_n_o,
    output logic laser_ctl_0_o,
    output logic laser_ctl_1_o,
    output logic laser_ctl_2_o,
    input wire logic beam_detect_in_n_i,
    input wire logic laser_intensity_ok_i,
    output logic video_ch1_p_o,
    output logic video_ch1_n_o,
    output logic video_ch2_p_o,
    output logic video_ch2_n_o,
    // Paper path
    output logic feed_motor_o,
    output logic drum_motor_o,
    output logic feed_clutch_o,
    output logic tray2_pickup_solenoid_o,
    input wire logic prefeed_sensor_i,
    input wire logic top_of_page_sensor_i,
    input wire logic delivery_sensor_i
);
    import spsq_pkg::*;

    typedef enum logic [3:0] {
        SPSQ_IDLE, SPSQ_SPIN, SPSQ_CLUTCH, SPSQ_PICK, SPSQ_STAGED, SPSQ_ADV,
        SPSQ_TOP, SPSQ_DELIV, SPSQ_CLEAR, SPSQ_ERASE, SPSQ_HALT
    } spsq_state_t;

    localparam int W = SPSQ_CNT_W;

    spsq_state_t state_r, state_nxt;
    logic bd_pulse, bd_inwin, bd_seen_r;
    logic [W-1:0] bd_int;
    logic [W-1:0] tmo_cnt, scan_cnt;
    logic tmo_exp, scan_exp, tmo_clr, state_chg;
    logic locked_r;
    logic [7:0] lock_cnt_r;
    logic laser_checked_r;
    logic scanning;
    logic fault;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    spsq_bd_meter #(.W(W)) u_bd (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .beam_detect_in_n_i(beam_detect_in_n_i),
        .nom_i(W'(BD_NOM_CYC)),
        .tol_i(W'(BD_TOL_CYC)),
        .bd_pulse_o(bd_pulse),
        .interval_o(bd_int),
        .in_window_o(bd_inwin),
        .seen_o()
    );

    // Per-state watchdog, restarted on every state change
    spsq_timer #(.W(W)) u_tmo (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .clear_i(tmo_clr),
        .run_i(state_r != SPSQ_IDLE && state_r != SPSQ_HALT),
        .limit_i(state_r == SPSQ_SPIN ? W'(SPINUP_CYC) :
            state_r == SPSQ_ERASE ? W'(LAST_ROT_CYC) : W'(SHEET_TMO_CYC)),
        .count_o(tmo_cnt),
        .expired_o(tmo_exp)
    );

    // Scanner start-up timer, from drive on until lock
    spsq_timer #(.W(W)) u_scan (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .clear_i(!scanning),
        .run_i(scanning && !locked_r),
        .limit_i(W'(SCAN_TMO_CYC)),
        .count_o(scan_cnt),
        .expired_o(scan_exp)
    );

    assign state_chg = state_nxt != state_r;
    assign tmo_clr = state_chg;
    assign scanning = state_r != SPSQ_IDLE && state_r != SPSQ_HALT;
    assign fault = laser_fail_o || bd_fail_o || scanner_fail_o || jam_o;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SPSQ_IDLE: if (print_cmd_i) state_nxt = SPSQ_SPIN;
            SPSQ_SPIN: if (tmo_exp) state_nxt = SPSQ_CLUTCH;
            SPSQ_CLUTCH: state_nxt = SPSQ_PICK;
            SPSQ_PICK: begin
                if (prefeed_sensor_i) state_nxt = SPSQ_STAGED;
                else if (tmo_exp) state_nxt = SPSQ_HALT;
            end
            SPSQ_STAGED: if (locked_r) state_nxt = SPSQ_ADV;
            SPSQ_ADV: begin
                if (top_of_page_sensor_i) state_nxt = SPSQ_TOP;
                else if (tmo_exp) state_nxt = SPSQ_HALT;
            end
            SPSQ_TOP: begin
                if (delivery_sensor_i) state_nxt = SPSQ_DELIV;
                else if (tmo_exp) state_nxt = SPSQ_HALT;
            end
            SPSQ_DELIV: begin
                if (!delivery_sensor_i && !top_of_page_sensor_i &&
                    !prefeed_sensor_i) state_nxt = SPSQ_ERASE;
                else if (tmo_exp) state_nxt = SPSQ_HALT;
            end
            SPSQ_ERASE: if (tmo_exp) state_nxt = SPSQ_IDLE;
            SPSQ_HALT: state_nxt = SPSQ_HALT;
            default: state_nxt = SPSQ_IDLE;
        endcase
        if (state_r != SPSQ_IDLE && state_r != SPSQ_HALT &&
            (laser_fail_o || bd_fail_o || scanner_fail_o)) begin
            state_nxt = SPSQ_HALT;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            state_r <= SPSQ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Speed lock from beam-detect timing
    always_ff @(posedge clock_i) begin
        if (!nrst_i || !scanning) begin
            lock_cnt_r <= 8'h00;
            locked_r <= 1'b0;
        end else if (bd_pulse) begin
            if (bd_inwin) begin
                if (lock_cnt_r != 8'(LOCK_LINES)) lock_cnt_r <= lock_cnt_r + 8'h01;
                if (lock_cnt_r + 8'h01 >= 8'(LOCK_LINES)) locked_r <= 1'b1;
            end else if (!locked_r) begin
                lock_cnt_r <= 8'h00;
            end
        end
    end

    // Drive on (low) while too slow, coast while too fast; full drive until the
    // first beam detect of this job, so a later print spins up from rest again
    always_ff @(posedge clock_i) begin
        if (!nrst_i || !scanning) begin
            scanner_speed_drive_n_o <= 1'b1;
            bd_seen_r <= 1'b0;
        end else if (!bd_seen_r) begin
            scanner_speed_drive_n_o <= 1'b0;
            bd_seen_r <= bd_pulse;
        end else if (bd_pulse) begin
            scanner_speed_drive_n_o <= !(bd_int > W'(BD_NOM_CYC));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Laser control and video
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            {laser_ctl_2_o, laser_ctl_1_o, laser_ctl_0_o} <= SPSQ_LCTL_OFF;
        end else if (state_r == SPSQ_ERASE) begin
            {laser_ctl_2_o, laser_ctl_1_o, laser_ctl_0_o} <= SPSQ_LCTL_ERASE;
        end else if (scanning && locked_r) begin
            {laser_ctl_2_o, laser_ctl_1_o, laser_ctl_0_o} <= SPSQ_LCTL_VIDEO;
        end else if (scanning) begin
            {laser_ctl_2_o, laser_ctl_1_o, laser_ctl_0_o} <= SPSQ_LCTL_FORCE;
        end else begin
            {laser_ctl_2_o, laser_ctl_1_o, laser_ctl_0_o} <= SPSQ_LCTL_OFF;
        end
    end

    // Each channel on its own pair; idle pairs rest at 0/1
    always_ff @(posedge clock_i) begin
        if (!nrst_i || !(scanning && locked_r && state_r != SPSQ_ERASE)) begin
            video_ch1_p_o <= 1'b0;
            video_ch1_n_o <= 1'b1;
            video_ch2_p_o <= 1'b0;
            video_ch2_n_o <= 1'b1;
        end else begin
            video_ch1_p_o <= video_ch1_i;
            video_ch1_n_o <= !video_ch1_i;
            video_ch2_p_o <= video_ch2_i;
            video_ch2_n_o <= !video_ch2_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Failure flags, sticky until the next print command from idle
    always_ff @(posedge clock_i) begin
        if (!nrst_i || (state_r == SPSQ_IDLE && print_cmd_i)) begin
            laser_checked_r <= 1'b0;
            laser_fail_o <= 1'b0;
        end else if (scanning && !laser_checked_r && scan_cnt == W'(LASER_CHK_CYC)) begin
            laser_checked_r <= 1'b1;
            laser_fail_o <= !laser_intensity_ok_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || (state_r == SPSQ_IDLE && print_cmd_i)) begin
            bd_fail_o <= 1'b0;
            scanner_fail_o <= 1'b0;
        end else begin
            if (locked_r && state_r != SPSQ_ERASE && !bd_inwin) bd_fail_o <= 1'b1;
            if (scan_exp) scanner_fail_o <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || (state_r == SPSQ_IDLE && print_cmd_i)) begin
            jam_o <= 1'b0;
        end else if (state_nxt == SPSQ_HALT && state_r != SPSQ_HALT && !fault &&
            !(laser_fail_o || bd_fail_o || scanner_fail_o)) begin
            jam_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Motors, clutch and solenoid
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            feed_motor_o <= 1'b0;
            drum_motor_o <= 1'b0;
            feed_clutch_o <= 1'b0;
            tray2_pickup_solenoid_o <= 1'b0;
        end else begin
            feed_motor_o <= state_nxt != SPSQ_IDLE && state_nxt != SPSQ_HALT;
            drum_motor_o <= state_nxt != SPSQ_IDLE && state_nxt != SPSQ_HALT;
            feed_clutch_o <= state_nxt == SPSQ_CLUTCH || state_nxt == SPSQ_PICK ||
                state_nxt == SPSQ_ADV || state_nxt == SPSQ_TOP;
            tray2_pickup_solenoid_o <= state_nxt == SPSQ_PICK;
        end
    end

    assign busy_o = scanning;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_vid_gated;
        @(posedge clock_i) disable iff (!nrst_i)
        (video_ch1_p_o || video_ch2_p_o) |-> $past(locked_r);
    endproperty
    a_vid_gated: assert property (p_vid_gated) else $error("video while unlocked");
    property p_pairs;
        @(posedge clock_i) disable iff (!nrst_i)
        (video_ch1_p_o != video_ch1_n_o) && (video_ch2_p_o != video_ch2_n_o);
    endproperty
    a_pairs: assert property (p_pairs) else $error("pair not differential");
    property p_start;
        @(posedge clock_i) disable iff (!nrst_i)
        (state_r == SPSQ_IDLE && print_cmd_i) |=> (feed_motor_o && drum_motor_o);
    endproperty
    a_start: assert property (p_start) else $error("motors not started");
    property p_stage;
        @(posedge clock_i) disable iff (!nrst_i)
        (state_r == SPSQ_STAGED) |-> !feed_clutch_o;
    endproperty
    a_stage: assert property (p_stage) else $error("clutch on while staged");
    property p_ready;
        @(posedge clock_i) disable iff (!nrst_i)
        (state_r == SPSQ_ADV) |-> locked_r;
    endproperty
    a_ready: assert property (p_ready) else $error("advance before ready");
    property p_erase;
        @(posedge clock_i) disable iff (!nrst_i)
        ({laser_ctl_2_o, laser_ctl_1_o, laser_ctl_0_o} == SPSQ_LCTL_ERASE) |->
            $past(state_r) == SPSQ_ERASE;
    endproperty
    a_erase: assert property (p_erase) else $error("erase outside last rotation");
    property p_scanfail;
        @(posedge clock_i) disable iff (!nrst_i)
        scan_exp |=> scanner_fail_o;
    endproperty
    a_scanfail: assert property (p_scanfail) else $error("scanner fail missed");
    property p_jam_halt;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(jam_o) |-> state_r == SPSQ_HALT ##1 !feed_motor_o;
    endproperty
    a_jam_halt: assert property (p_jam_halt) else $error("jam without halt");
    property p_force;
        @(posedge clock_i) disable iff (!nrst_i)
        (scanning && !locked_r && state_r != SPSQ_ERASE) |=>
            ({laser_ctl_2_o, laser_ctl_1_o, laser_ctl_0_o} == SPSQ_LCTL_FORCE || !scanning ||
            locked_r || state_r == SPSQ_ERASE);
    endproperty
    a_force: assert property (p_force) else $error("laser not forced");
    c_lock: cover property (@(posedge clock_i) disable iff (!nrst_i) $rose(locked_r));
    c_jam: cover property (@(posedge clock_i) disable iff (!nrst_i) $rose(jam_o));
    c_done: cover property (@(posedge clock_i) disable iff (!nrst_i)
        state_r == SPSQ_ERASE ##1 state_r == SPSQ_IDLE);
endmodule : spsq_sequencer

//--- spsq_scan_model.sv
`timescale 1ns/1ps
// Scanner unit: mirror spins once driven, beam detect returns while the laser is on
module spsq_scan_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Bench control
    input wire logic bd_en_i,
    input wire logic [15:0] period_i,
    input wire logic power_good_i,
    // Sequencer side
    input wire logic drive_n_i,
    input wire logic [2:0] laser_ctl_i,
    output logic beam_detect_in_n_o,
    output logic laser_intensity_ok_o
);
    logic spin_r;
    logic [15:0] cnt_r;
    logic lit;

    assign lit = (laser_ctl_i != 3'h0);

    // Mirror keeps turning on its inertia until the laser is shut off
    always_ff @(posedge clock_i) begin
        if (!nrst_i || (!lit && drive_n_i)) begin
            spin_r <= 1'b0;
        end else if (!drive_n_i) begin
            spin_r <= 1'b1;
        end
    end

    // One facet per period; a shorter period takes effect at once
    always_ff @(posedge clock_i) begin
        if (!nrst_i || !spin_r || !lit) begin
            cnt_r <= 16'h0;
        end else if (cnt_r >= period_i - 16'h1) begin
            cnt_r <= 16'h0;
        end else begin
            cnt_r <= cnt_r + 16'h1;
        end
    end

    assign beam_detect_in_n_o = !(spin_r && lit && bd_en_i && cnt_r < 16'h2);
    assign laser_intensity_ok_o = power_good_i && lit;
endmodule : spsq_scan_model

//--- scanner_and_pickup_sequencer_tb_top.sv
`timescale 1ns/1ps
module scanner_and_pickup_sequencer_tb_top;
    import spsq_pkg::*;
    logic clock_i = 0, nrst = 0, pcmd = 0, vid1 = 0, vid2 = 0;
    logic pf = 0, tp = 0, dl = 0, bd_en = 0, pgood = 1;
    logic [15:0] period = 16'h64;
    logic lf, bf, sf, jam, busy, drv_n, lc0, lc1, lc2, p1, n1, p2, n2;
    logic fm, dm, clu, sol, bd_n, iok;
    logic [2:0] lctl;
    int bad_count = 0, cmp_count = 0, cyc = 0;

    assign lctl = {lc2, lc1, lc0};

    spsq_sequencer #(.SCAN_TMO_CYC(26000), .BD_NOM_CYC(100),
        .BD_TOL_CYC(5), .SHEET_TMO_CYC(2000),
        .LAST_ROT_CYC(200)) dut (.clock_i(clock_i), .nrst_i(nrst), .print_cmd_i(pcmd),
        .video_ch1_i(vid1), .video_ch2_i(vid2), .laser_fail_o(lf), .bd_fail_o(bf),
        .scanner_fail_o(sf), .jam_o(jam), .busy_o(busy), .scanner_speed_drive_n_o(drv_n),
        .laser_ctl_0_o(lc0), .laser_ctl_1_o(lc1), .laser_ctl_2_o(lc2),
        .beam_detect_in_n_i(bd_n), .laser_intensity_ok_i(iok), .video_ch1_p_o(p1),
        .video_ch1_n_o(n1), .video_ch2_p_o(p2), .video_ch2_n_o(n2), .feed_motor_o(fm),
        .drum_motor_o(dm), .feed_clutch_o(clu), .tray2_pickup_solenoid_o(sol),
        .prefeed_sensor_i(pf), .top_of_page_sensor_i(tp), .delivery_sensor_i(dl));

    spsq_scan_model model (.clock_i(clock_i), .nrst_i(nrst), .bd_en_i(bd_en),
        .period_i(period), .power_good_i(pgood), .drive_n_i(drv_n), .laser_ctl_i(lctl),
        .beam_detect_in_n_o(bd_n), .laser_intensity_ok_o(iok));

    initial begin
        forever #10 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard well above the longest expected run
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step

    task automatic do_reset;
        nrst = 0;
        step(12);
        nrst = 1;
    endtask : do_reset

    task automatic start_print;
        pcmd = 1;
        step(1);
        pcmd = 0;
        step(1);
    endtask : start_print

    task automatic idle_check(input string what);
        chk({fm, dm, clu, sol}, 4'h0, what);
        chk({drv_n, lctl}, 4'h8, what);
        chk({p1, n1, p2, n2}, 4'h5, what);
    endtask : idle_check

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_print;
        int i;
        do_reset();
        idle_check("reset outputs");
        chk({lf, bf, sf, jam}, 4'h0, "reset flags");
        bd_en = 1;
        vid1 = 1;
        start_print();
        chk({fm, dm, busy}, 4'h7, "motors on");
        chk({drv_n, lctl}, 4'h7, "drive and force");
        chk({p1, n1, p2, n2}, 4'h5, "no video before lock");
        i = 0;
        while (clu !== 1'b1 && i < SPSQ_MOTOR_SPINUP_CYC + 20) begin step(1); i++; end
        chk({clu, sol}, 4'h2, "clutch before solenoid");
        step(1);
        chk({clu, sol}, 4'h3, "solenoid picks");
        pf = 1;
        step(2);
        chk({clu, lctl}, 4'h7, "sheet staged");
        step(100);
        chk({3'h0, clu}, 4'h0, "held until ready");
        i = 0;
        while (lctl !== SPSQ_LCTL_VIDEO && i < 1500) begin step(1); i++; end
        chk({1'b0, lctl}, {1'b0, SPSQ_LCTL_VIDEO}, "scanner locked");
        step(3);
        chk({3'h0, clu}, 4'h1, "clutch re-engaged");
        vid2 = 0;
        step(2);
        chk({p1, n1, p2, n2}, 4'h9, "video 10");
        vid1 = 0;
        vid2 = 1;
        step(2);
        chk({p1, n1, p2, n2}, 4'h6, "video 01");
        chk({1'b0, lctl}, {1'b0, SPSQ_LCTL_VIDEO}, "no erase while printing");
        tp = 1;
        step(5);
        dl = 1;
        step(5);
        {pf, tp, dl} = 3'h0;
        i = 0;
        while (lctl !== SPSQ_LCTL_ERASE && i < 20) begin step(1); i++; end
        chk({1'b0, lctl}, {1'b0, SPSQ_LCTL_ERASE}, "erase after print");
        i = 0;
        while (busy !== 1'b0 && i < 400) begin step(1); i++; end
        chk({3'h0, i >= 195 && i <= 205}, 4'h1, "erase length");
        step(2);
        idle_check("idle after print");
        chk({lf, bf, sf, jam}, 4'h0, "clean print flags");
        start_print();
        chk({drv_n, lctl}, 4'h7, "drive on second print");
        $display("test print done");
    endtask : t_print

    task automatic t_laser_fail;
        int i;
        do_reset();
        pgood = 0;
        bd_en = 0;
        pf = 1;
        start_print();
        i = 0;
        while (lf !== 1'b1 && i < SPSQ_LASER_CHK_CYC + 100) begin step(1); i++; end
        chk({3'h0, lf}, 4'h1, "laser failure");
        chk({3'h0, i >= SPSQ_LASER_CHK_CYC - 20}, 4'h1, "laser check time");
        step(3);
        idle_check("halt on laser failure");
        start_print();
        chk({3'h0, busy}, 4'h0, "command refused in halt");
        pgood = 1;
        bd_en = 1;
        pf = 0;
        $display("test laser failure done");
    endtask : t_laser_fail

    task automatic t_scan_fail;
        int i;
        do_reset();
        bd_en = 0;
        pf = 1;
        start_print();
        i = 0;
        while (sf !== 1'b1 && i < 27000) begin step(1); i++; end
        chk({lf, bf, sf, jam}, 4'h2, "scanner start-up failure");
        chk({3'h0, i >= 25900}, 4'h1, "start-up timeout");
        bd_en = 1;
        pf = 0;
        $display("test scanner failure done");
    endtask : t_scan_fail

    task automatic t_bd_fail;
        int i;
        do_reset();
        start_print();
        i = 0;
        while (lctl !== SPSQ_LCTL_VIDEO && i < 2000) begin step(1); i++; end
        period = 16'h67;
        step(350);
        chk({bf, drv_n}, 4'h0, "slow line speeds up");
        period = 16'h61;
        step(350);
        chk({bf, drv_n}, 4'h1, "fast line slows down");
        period = 16'h82;
        i = 0;
        while (bf !== 1'b1 && i < 300) begin step(1); i++; end
        chk({lf, bf, sf, jam}, 4'h4, "beam-detect failure");
        period = 16'h64;
        $display("test beam detect done");
    endtask : t_bd_fail

    task automatic t_jam;
        int i;
        do_reset();
        start_print();
        i = 0;
        while (jam !== 1'b1 && i < SPSQ_MOTOR_SPINUP_CYC + 2100) begin step(1); i++; end
        chk({lf, bf, sf, jam}, 4'h1, "jam raised");
        chk({3'h0, i >= SPSQ_MOTOR_SPINUP_CYC + 1900}, 4'h1, "jam timeout");
        step(3);
        idle_check("halt on jam");
        chk({3'h0, busy}, 4'h0, "print stopped");
        $display("test jam done");
    endtask : t_jam

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1;
        t_print();
        t_laser_fail();
        t_scan_fail();
        t_bd_fail();
        t_jam();
        tally_and_finish();
    end
endmodule : scanner_and_pickup_sequencer_tb_top
